// file: eipu_map.svh
// Register indices, field positions and reset values of the external pin interrupt unit
`ifndef EIPU_MAP_SVH
`define EIPU_MAP_SVH
`define EIPU_IDX_GROUP_FLAGS 6'h36
`define EIPU_IDX_MASK_ZERO 6'h37
`define EIPU_IDX_MASK_ONE 6'h38
`define EIPU_IDX_MASK_TWO 6'h39
`define EIPU_IDX_SENSE_CTRL 6'h3a
`define EIPU_IDX_FLAGS 6'h3b
`define EIPU_IDX_GROUP_EN 6'h3c
`define EIPU_IDX_ENABLE_MASK 6'h3d
`define EIPU_RST_BYTE 8'h00
`define EIPU_RST_SENSE 4'h0
`define EIPU_RST_PAIR 2'h0
`define EIPU_RST_GROUP 3'h0
`define EIPU_RST_MASK_ONE 7'h00
`define EIPU_VEC_PIN_A 0
`define EIPU_VEC_PIN_B 1
`define EIPU_VEC_GROUP0 2
`define EIPU_VEC_GROUP1 3
`define EIPU_VEC_GROUP2 4
`define EIPU_GRP0_LO 0
`define EIPU_GRP0_HI 7
`define EIPU_GRP1_LO 8
`define EIPU_GRP1_HI 14
`define EIPU_GRP2_LO 16
`define EIPU_GRP2_HI 23
`endif

// file: eipu_pkg.sv
// Types of the external pin interrupt unit
package eipu_pkg;
  typedef enum logic [1:0] {
    eipu_sense_low,
    eipu_sense_any,
    eipu_sense_fall,
    eipu_sense_rise
  } eipu_sense_type;
  typedef logic [7:0] eipu_byte_type;
endpackage

// file: eipu_top.sv
// External pin interrupt unit: two sensed pins, three pin-change groups, Avalon-MM registers
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "eipu_map.svh"

module eipu_top
  import eipu_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic irq_pin_a_in,
  input wire logic irq_pin_b_in,
  input wire logic [23:0] pin_change_inputs_in,
  input wire logic global_irq_en_in,
  input wire logic io_clk_run_in,
  input wire logic [4:0] vector_ack_in,
  output logic [4:0] irq_request_out,
  output logic wake_out
);

  // Bus side
  logic wait_q;
  logic [31:0] readdata_q;
  logic [5:0] reg_idx;
  logic bus_req;
  logic accept;
  logic wr_lane0;
  eipu_byte_type wdata;
  eipu_byte_type rd_byte;

  // Control and status
  logic [3:0] sense_q;
  logic [1:0] enable_q;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [2:0] grp_en_q;
  logic [2:0] grp_flag_q;
  logic [2:0] grp_flag_d;
  eipu_byte_type mask0_q;
  logic [6:0] mask1_q;
  eipu_byte_type mask2_q;
  logic [4:0] irq_q;
  logic [4:0] irq_d;
  logic wake_q;

  // Pin sampling
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_prev_q;
  logic [23:0] pc_meta_q;
  logic [23:0] pc_sync_q;
  logic [23:0] pc_prev_q;
  logic [23:0] mask_all;
  logic [23:0] pc_change;
  logic [2:0] grp_evt;
  logic [1:0] level_low;
  logic [1:0] level_mode;
  logic [1:0] edge_evt;

  assign reg_idx = avs_address_in[7:2];
  assign bus_req = avs_read_in | avs_write_in;
  assign accept = bus_req & ~wait_q;
  assign wr_lane0 = avs_write_in & accept & avs_byteenable_in[0];
  assign wdata = avs_writedata_in[7:0];

  logic wr_sense;
  logic wr_enable;
  logic wr_flags;
  logic wr_grp_en;
  logic wr_grp_flags;
  logic wr_mask0;
  logic wr_mask1;
  logic wr_mask2;
  assign wr_sense = wr_lane0 & (reg_idx == `EIPU_IDX_SENSE_CTRL);
  assign wr_enable = wr_lane0 & (reg_idx == `EIPU_IDX_ENABLE_MASK);
  assign wr_flags = wr_lane0 & (reg_idx == `EIPU_IDX_FLAGS);
  assign wr_grp_en = wr_lane0 & (reg_idx == `EIPU_IDX_GROUP_EN);
  assign wr_grp_flags = wr_lane0 & (reg_idx == `EIPU_IDX_GROUP_FLAGS);
  assign wr_mask0 = wr_lane0 & (reg_idx == `EIPU_IDX_MASK_ZERO);
  assign wr_mask1 = wr_lane0 & (reg_idx == `EIPU_IDX_MASK_ONE);
  assign wr_mask2 = wr_lane0 & (reg_idx == `EIPU_IDX_MASK_TWO);

  // Unused high bits pad with zero; unmapped indices read zero
  assign rd_byte = (reg_idx == `EIPU_IDX_SENSE_CTRL) ? {4'h0, sense_q} :
                   (reg_idx == `EIPU_IDX_ENABLE_MASK) ? {6'h00, enable_q} :
                   (reg_idx == `EIPU_IDX_FLAGS) ? {6'h00, flag_q} :
                   (reg_idx == `EIPU_IDX_GROUP_EN) ? {5'h00, grp_en_q} :
                   (reg_idx == `EIPU_IDX_GROUP_FLAGS) ? {5'h00, grp_flag_q} :
                   (reg_idx == `EIPU_IDX_MASK_ZERO) ? mask0_q :
                   (reg_idx == `EIPU_IDX_MASK_ONE) ? {1'b0, mask1_q} :
                   (reg_idx == `EIPU_IDX_MASK_TWO) ? mask2_q : `EIPU_RST_BYTE;

  // One wait cycle per access: data is registered, so every output stays a flop
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      if (avs_read_in && wait_q) begin
        readdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sense_q <= `EIPU_RST_SENSE;
      enable_q <= `EIPU_RST_PAIR;
      grp_en_q <= `EIPU_RST_GROUP;
      mask0_q <= `EIPU_RST_BYTE;
      mask1_q <= `EIPU_RST_MASK_ONE;
      mask2_q <= `EIPU_RST_BYTE;
    end else begin
      if (wr_sense) sense_q <= wdata[3:0];
      if (wr_enable) enable_q <= wdata[1:0];
      if (wr_grp_en) grp_en_q <= wdata[2:0];
      if (wr_mask0) mask0_q <= wdata;
      if (wr_mask1) mask1_q <= wdata[6:0];
      if (wr_mask2) mask2_q <= wdata;
    end
  end

  // Pads are read regardless of pin direction, so driving them raises requests too
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_q <= 2'b00;
      pin_sync_q <= 2'b00;
      pin_prev_q <= 2'b00;
      pc_meta_q <= 24'h000000;
      pc_sync_q <= 24'h000000;
      pc_prev_q <= 24'h000000;
    end else begin
      pin_meta_q <= {irq_pin_b_in, irq_pin_a_in};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      pc_meta_q <= pin_change_inputs_in;
      pc_sync_q <= pc_meta_q;
      pc_prev_q <= pc_sync_q;
    end
  end

  // Dedicated pins, one slice each: pin a sense in bits 1:0, pin b in bits 3:2
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      eipu_sense_type mode;
      logic rise;
      logic fall;
      logic clr;
      assign mode = eipu_sense_type'(sense_q[2*gi+1:2*gi]);
      assign rise = pin_sync_q[gi] & ~pin_prev_q[gi];
      assign fall = ~pin_sync_q[gi] & pin_prev_q[gi];
      assign level_mode[gi] = (mode == eipu_sense_low);
      assign level_low[gi] = level_mode[gi] & ~pin_sync_q[gi];
      // Edge logic lives on the I/O clock; a halted clock loses edges
      assign edge_evt[gi] = io_clk_run_in &
                            (((mode == eipu_sense_any) & (rise | fall)) |
                             ((mode == eipu_sense_fall) & fall) |
                             ((mode == eipu_sense_rise) & rise));
      assign clr = (wr_flags & wdata[gi]) | vector_ack_in[gi];
      // Set wins over a simultaneous clear
      assign flag_d[gi] = ~level_mode[gi] & (edge_evt[gi] | (flag_q[gi] & ~clr));
      // Level request follows the live pin, so a level gone before start-up requests nothing
      assign irq_d[gi] = global_irq_en_in & enable_q[gi] &
                         (level_mode[gi] ? level_low[gi] : flag_q[gi]);
    end
  endgenerate

  // Bit 15 has no line behind it
  assign mask_all = {mask2_q, 1'b0, mask1_q, mask0_q};

  genvar bj;
  generate
    for (bj = 0; bj < 24; bj++) begin : g_change
      // No I/O clock term: changes count in every sleep mode
      assign pc_change[bj] = (pc_sync_q[bj] ^ pc_prev_q[bj]) & mask_all[bj];
    end
  endgenerate

  assign grp_evt[0] = |pc_change[`EIPU_GRP0_HI:`EIPU_GRP0_LO];
  assign grp_evt[1] = |pc_change[`EIPU_GRP1_HI:`EIPU_GRP1_LO];
  assign grp_evt[2] = |pc_change[`EIPU_GRP2_HI:`EIPU_GRP2_LO];

  genvar gk;
  generate
    for (gk = 0; gk < 3; gk++) begin : g_group
      logic clr;
      assign clr = (wr_grp_flags & wdata[gk]) | vector_ack_in[`EIPU_VEC_GROUP0 + gk];
      assign grp_flag_d[gk] = grp_evt[gk] | (grp_flag_q[gk] & ~clr);
      assign irq_d[`EIPU_VEC_GROUP0 + gk] = global_irq_en_in & grp_en_q[gk] & grp_flag_q[gk];
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_q <= `EIPU_RST_PAIR;
      grp_flag_q <= `EIPU_RST_GROUP;
      irq_q <= 5'h00;
      wake_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      grp_flag_q <= grp_flag_d;
      irq_q <= irq_d;
      // Wake ignores the global flag: sleep exit comes before vectoring
      wake_q <= (|(level_low & enable_q)) | (|(grp_flag_q & grp_en_q));
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = readdata_q;
  assign irq_request_out = irq_q;
  assign wake_out = wake_q;

  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  a_level_keeps_requesting: assert property (
    (sense_q[1:0] == 2'b00 && enable_q[0] && global_irq_en_in && !pin_sync_q[0])
      |=> irq_request_out[`EIPU_VEC_PIN_A])
    else $error("level mode pin a low but no request");

  a_level_flag_clear: assert property (
    (sense_q[3:2] == 2'b00) |=> !flag_q[1])
    else $error("pin b flag set in level mode");

  a_falling_sets_flag: assert property (
    (sense_q[1:0] == 2'b10 && io_clk_run_in && pin_prev_q[0] && !pin_sync_q[0] && !wr_sense)
      |=> flag_q[0])
    else $error("falling edge on pin a did not set its flag");

  a_rising_ignored_fall: assert property (
    (sense_q[3:2] == 2'b11 && !flag_q[1] && !(pin_sync_q[1] && !pin_prev_q[1]) && !wr_sense)
      |=> !flag_q[1])
    else $error("pin b flag set without a rising edge");

  a_halted_no_edge: assert property (
    (!io_clk_run_in && !flag_q[0]) |=> !flag_q[0])
    else $error("edge caught while io clock halted");

  // First two edges after reset still show the synchroniser's reset zeros
  a_sync_two_stage: assert property (
    $past(rst_b_in, 2) |-> pin_sync_q[0] == $past(irq_pin_a_in, 2))
    else $error("pin a synchroniser depth wrong");

  a_unmasked_quiet: assert property (
    (mask0_q == 8'h00 && !grp_flag_q[0]) |=> !grp_flag_q[0])
    else $error("group zero flag set with all lines masked");

  a_group_two_sets: assert property (
    (|((pc_sync_q[23:16] ^ pc_prev_q[23:16]) & mask2_q)) |=> grp_flag_q[2])
    else $error("upper line change did not set group two flag");

  a_pin_request_gate: assert property (
    irq_request_out[`EIPU_VEC_PIN_B] |-> $past(enable_q[1]) && $past(global_irq_en_in))
    else $error("pin b request without enable and global flag");

  a_group_set_wins: assert property (
    (grp_evt[1] && vector_ack_in[`EIPU_VEC_GROUP1]) |=> grp_flag_q[1] ##1 irq_request_out[3] || !grp_en_q[1]
      || !$past(global_irq_en_in))
    else $error("group one event lost against clear");

  a_reserved_read_zero: assert property (
    (avs_read_in && wait_q && reg_idx == `EIPU_IDX_SENSE_CTRL) |=> avs_readdata_out[7:4] == 4'h0
      && !avs_waitrequest_out)
    else $error("reserved control bits read nonzero");

  a_bus_one_wait: assert property (
    (bus_req && wait_q) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not after exactly one wait cycle");

  a_group_zero_sets: assert property (
    (|((pc_sync_q[`EIPU_GRP0_HI:`EIPU_GRP0_LO] ^ pc_prev_q[`EIPU_GRP0_HI:`EIPU_GRP0_LO]) & mask0_q))
      |=> grp_flag_q[0])
    else $error("lower line change did not set group zero flag");

  a_group_one_sets: assert property (
    (|((pc_sync_q[`EIPU_GRP1_HI:`EIPU_GRP1_LO] ^ pc_prev_q[`EIPU_GRP1_HI:`EIPU_GRP1_LO]) & mask1_q))
      |=> grp_flag_q[1])
    else $error("middle line change did not set group one flag");

  a_group_one_quiet: assert property (
    (!grp_flag_q[1] &&
     !(|((pc_sync_q[`EIPU_GRP1_HI:`EIPU_GRP1_LO] ^ pc_prev_q[`EIPU_GRP1_HI:`EIPU_GRP1_LO]) & mask1_q)))
      |=> !grp_flag_q[1])
    else $error("group one flag set without a masked change");

  a_group_request_gate: assert property (
    irq_request_out[`EIPU_VEC_GROUP2]
      |-> $past(grp_en_q[2]) && $past(global_irq_en_in) && $past(grp_flag_q[2]))
    else $error("group two request without flag, enable and global flag");

  a_pin_flag_requests: assert property (
    (sense_q[1:0] != 2'b00 && flag_q[0] && enable_q[0] && global_irq_en_in)
      |=> irq_request_out[`EIPU_VEC_PIN_A])
    else $error("pin a flag set and enabled but no request");

  a_any_change_b: assert property (
    (sense_q[3:2] == 2'b01 && io_clk_run_in && (pin_sync_q[1] != pin_prev_q[1]))
      |=> flag_q[1])
    else $error("change on pin b in any-change mode did not set its flag");

  a_enable_read_zero: assert property (
    (avs_read_in && wait_q && reg_idx == `EIPU_IDX_ENABLE_MASK)
      |=> avs_readdata_out[7:2] == 6'h00)
    else $error("reserved enable bits read nonzero");

  a_level_wakes: assert property (
    (level_low[0] && enable_q[0])
      |=> wake_out)
    else $error("enabled low level on pin a did not request wake");

  a_flag_w1c: assert property (
    (flag_q[0] && !edge_evt[0] && wr_flags && wdata[0])
      |=> !flag_q[0])
    else $error("written one did not clear pin a flag");

  c_level_request: cover property (level_low[0] && enable_q[0] ##1 irq_request_out[0]);
  c_any_change_b: cover property (sense_q[3:2] == 2'b01 && edge_evt[1] ##2 irq_request_out[1]);
  c_group_two_irq: cover property (grp_evt[2] && grp_en_q[2] ##2 irq_request_out[4]);
  c_flag_w1c: cover property (flag_q[0] && wr_flags && wdata[0] ##1 !flag_q[0]);
  c_set_beats_ack: cover property (grp_evt[1] && vector_ack_in[`EIPU_VEC_GROUP1] ##1 grp_flag_q[1]);

endmodule

// file: eipu_pin_model.sv
// Board-side model of the two dedicated interrupt pins and the pin-change lines
`timescale 1ns/1ps
module eipu_pin_model (
  input wire logic clock_in,
  output logic pin_a_out,
  output logic pin_b_out,
  output logic [23:0] change_out
);
  // Pulled-up lines idle high
  initial begin
    pin_a_out = 1'b1;
    pin_b_out = 1'b1;
    change_out = 24'hffffff;
  end
  // Same pad level whether the board or the chip's own output drives it
  // Levels move just after an edge and stand for hold cycles, never shorter than a clock
  task automatic drive(input logic a, input logic b, input logic [23:0] c, input int hold);
    @(posedge clock_in);
    pin_a_out <= a;
    pin_b_out <= b;
    change_out <= c;
    repeat (hold) @(posedge clock_in);
  endtask
endmodule

// file: external_pin_interrupt_unit_test.sv
// Self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`include "eipu_map.svh"
module external_pin_interrupt_unit_test;
  import eipu_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wait_rq;
  logic pa;
  logic pb;
  logic [23:0] pc;
  logic gie = 1'b0;
  logic io_run = 1'b1;
  logic [4:0] ack = 5'h00;
  logic [4:0] irq;
  logic wake;
  int fails = 0;
  int check_count = 0;
  int seed = 32'h94ee80c7;
  logic [13:0] rd_q[$];
  logic [5:0] irq_q[$];
  logic [13:0] re;
  logic [23:0] pcv = 24'hffffff;
  logic [5:0] f;
  int lo;
  int w;
  int b;
  event snap;
  always #50 clock_in = ~clock_in;
  eipu_top i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_rq), .irq_pin_a_in(pa), .irq_pin_b_in(pb), .pin_change_inputs_in(pc),
    .global_irq_en_in(gie), .io_clk_run_in(io_run), .vector_ack_in(ack), .irq_request_out(irq),
    .wake_out(wake));
  eipu_pin_model i_pins (.clock_in(clock_in), .pin_a_out(pa), .pin_b_out(pb), .change_out(pc));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_read(logic [5:0] idx, logic [7:0] exp, logic [31:0] got);
    check_count++;
    if (got !== {24'h000000, exp}) begin
      fails++;
      $display("[ERR] reg %h expected %h seen %h", idx, exp, got);
    end
  endtask
  task automatic cmp_irq(logic [5:0] exp, logic [5:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] wake_irq expected %h seen %h", exp, got);
    end
  endtask
  // Request stands until the edge that sees waitrequest low
  task automatic bus(input logic wnr, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    adr <= {idx, 2'b00};
    rd <= !wnr;
    wr <= wnr;
    wdat <= {24'($random(seed)), d};
    do begin
      @(posedge clock_in);
      n++;
      if (n > 20) begin
        fails++;
        tally_and_finish();
      end
    end while (wait_rq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_reg(logic [5:0] idx, logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd_reg(logic [5:0] idx, logic [7:0] e);
    rd_q.push_back({idx, e});
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic expect_irq(logic [5:0] e);
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    irq_q.push_back(e);
    -> snap;
    @(posedge clock_in);
  endtask
  task automatic pulse_ack(logic [4:0] v);
    ack <= v;
    @(posedge clock_in);
    ack <= 5'h00;
  endtask
  always @(posedge clock_in) begin
    if (rd && wait_rq === 1'b0) begin
      re = rd_q.pop_front();
      cmp_read(re[13:8], re[7:0], rdat);
    end
  end
  always @(snap) cmp_irq(irq_q.pop_front(), {wake, irq});
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    for (int i = `EIPU_IDX_GROUP_FLAGS; i <= `EIPU_IDX_ENABLE_MASK; i++) rd_reg(6'(i), 8'h00);
    rd_reg(6'h10, 8'h00);
    wr_reg(`EIPU_IDX_ENABLE_MASK, 8'hff);
    rd_reg(`EIPU_IDX_ENABLE_MASK, 8'h03);
    wr_reg(`EIPU_IDX_SENSE_CTRL, 8'hff);
    rd_reg(`EIPU_IDX_SENSE_CTRL, 8'h0f);
    wr_reg(`EIPU_IDX_FLAGS, 8'hff);
    rd_reg(`EIPU_IDX_FLAGS, 8'h00);
    be <= 4'h0;
    wr_reg(`EIPU_IDX_ENABLE_MASK, 8'h00);
    be <= 4'hf;
    rd_reg(`EIPU_IDX_ENABLE_MASK, 8'h03);
    $display("test registers done");
    gie <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(`EIPU_IDX_SENSE_CTRL, 8'(m << (2 * p)));
        i_pins.drive(p != 0, p == 0, pcv, 6);
        f = (m == 1 || m == 2) ? 6'(1 << p) : 6'h00;
        if (m == 0) begin
          expect_irq(6'h20 | 6'(1 << p));
          gie <= 1'b0;
          expect_irq(6'h20);
          gie <= 1'b1;
        end else begin
          expect_irq(f);
        end
        rd_reg(`EIPU_IDX_FLAGS, {2'b00, f});
        pulse_ack(5'(1 << p));
        rd_reg(`EIPU_IDX_FLAGS, 8'h00);
        i_pins.drive(1'b1, 1'b1, pcv, 6);
        f = (m == 1 || m == 3) ? 6'(1 << p) : 6'h00;
        rd_reg(`EIPU_IDX_FLAGS, {2'b00, f});
        wr_reg(`EIPU_IDX_FLAGS, 8'h03);
        rd_reg(`EIPU_IDX_FLAGS, 8'h00);
      end
    end
    // Edges while the I/O clock is halted are lost, not deferred
    wr_reg(`EIPU_IDX_SENSE_CTRL, 8'h02);
    io_run <= 1'b0;
    i_pins.drive(1'b0, 1'b1, pcv, 6);
    io_run <= 1'b1;
    rd_reg(`EIPU_IDX_FLAGS, 8'h00);
    i_pins.drive(1'b1, 1'b1, pcv, 6);
    $display("test pin sense done");
    wr_reg(`EIPU_IDX_GROUP_EN, 8'h07);
    io_run <= 1'b0;
    for (int g = 0; g < 3; g++) begin
      lo = 8 * g;
      w = (g == 1) ? 7 : 8;
      b = $unsigned($random(seed)) % w;
      wr_reg(6'(`EIPU_IDX_MASK_ZERO + g), 8'(1 << b));
      pcv[lo + (b + 1) % w] ^= 1'b1;
      pcv[15] ^= 1'b1;
      i_pins.drive(1'b1, 1'b1, pcv, 6);
      rd_reg(`EIPU_IDX_GROUP_FLAGS, 8'h00);
      pcv[lo + b] ^= 1'b1;
      // Vector entry held through the detecting edge must not swallow the new event
      fork
        i_pins.drive(1'b1, 1'b1, pcv, 6);
        begin
          @(posedge clock_in);
          ack <= 5'(4 << g);
          repeat (3) @(posedge clock_in);
          ack <= 5'h00;
        end
      join
      expect_irq(6'h20 | 6'(4 << g));
      rd_reg(`EIPU_IDX_GROUP_FLAGS, 8'(1 << g));
      pulse_ack(5'(4 << g));
      rd_reg(`EIPU_IDX_GROUP_FLAGS, 8'h00);
      pcv[lo + b] ^= 1'b1;
      i_pins.drive(1'b1, 1'b1, pcv, 6);
      rd_reg(`EIPU_IDX_GROUP_FLAGS, 8'(1 << g));
      wr_reg(`EIPU_IDX_GROUP_FLAGS, 8'(1 << g));
      rd_reg(`EIPU_IDX_GROUP_FLAGS, 8'h00);
    end
    $display("test pin change done");
    tally_and_finish();
  end
endmodule
